// *** rtc_mem_model.sv ***
`timescale 1ns/1ps
module rtc_mem_model (
	input  wire logic clk_sys_i,
	input  wire logic rstn_i,
	input  wire logic bus_request_i,
	input  wire logic refresh_active_i,
	input  wire logic refresh_strobe_n_i,
	input  wire logic refresh_strobe_oe_i,
	output logic      bus_grant_o,
	output logic      area3_wait_o,
	output int        refresh_count_o
);
	logic       slow_r;
	logic       act_r;
	logic       strb_r;
	logic [1:0] dly_r;
	// grant at once or two cycles late, alternating; one wait when slow
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			slow_r <= 1'b0;
			act_r <= 1'b0;
			strb_r <= 1'b1;
			dly_r <= 2'h0;
			bus_grant_o <= 1'b0;
			area3_wait_o <= 1'b0;
			refresh_count_o <= 0;
		end else begin
			dly_r <= bus_request_i ? dly_r + 2'h1 : 2'h0;
			bus_grant_o <= bus_request_i && dly_r >= {slow_r, 1'b0};
			act_r <= refresh_active_i;
			slow_r <= slow_r ^ (refresh_active_i && !act_r);
			area3_wait_o <= slow_r && refresh_active_i && !act_r;
			strb_r <= refresh_strobe_n_i;
			if (refresh_strobe_oe_i && strb_r && !refresh_strobe_n_i)
				refresh_count_o <= refresh_count_o + 1;
		end
	end
endmodule

// *** rtc_pkg.sv ***
package rtc_pkg;

	localparam logic [7:0] RTC_OFS_MODE  = 8'h00;
	localparam logic [7:0] RTC_OFS_CSR   = 8'h04;
	localparam logic [7:0] RTC_OFS_COUNT = 8'h08;
	localparam logic [7:0] RTC_OFS_CONST = 8'h0c;

	localparam int RTC_MODE_SELF  = 7;
	localparam int RTC_MODE_PSRAM = 6;
	localparam int RTC_MODE_DRAM  = 5;
	localparam int RTC_MODE_STRB  = 4;
	localparam int RTC_MODE_COL9  = 3;
	localparam int RTC_MODE_PIN   = 2;
	localparam int RTC_MODE_RCYC  = 0;

	localparam int RTC_CSR_FLAG = 7;
	localparam int RTC_CSR_IE   = 6;
	localparam int RTC_CSR_CKS  = 3;

	localparam logic [7:0] RTC_MODE_RST  = 8'h02;
	localparam logic [7:0] RTC_MODE_RSVD = 8'h02;
	localparam logic [2:0] RTC_CSR_RSVD  = 3'h7;
	localparam logic [7:0] RTC_COUNT_RST = 8'h00;
	localparam logic [7:0] RTC_CONST_RST = 8'hff;
	localparam logic [2:0] RTC_CKS_RST   = 3'h0;

	localparam logic [1:0] RTC_CYCLE_STATES = 2'h3;
	localparam logic [1:0] RTC_WAIT_STATE   = 2'h2;

	localparam logic [11:0] RTC_DIV_MASK [8] = '{
		12'h000, 12'h001, 12'h007, 12'h01f,
		12'h07f, 12'h1ff, 12'h7ff, 12'hfff};

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} rtc_aphase_type;

	typedef struct packed {
		logic self_refresh;
		logic psram;
		logic dram;
		logic two_cas;
		logic col9;
		logic pin_en;
		logic rcyc_en;
	} rtc_mode_type;

	typedef enum logic [3:0] {
		RTC_ST_IDLE   = 4'b0001,
		RTC_ST_PEND   = 4'b0010,
		RTC_ST_BUSREQ = 4'b0100,
		RTC_ST_CYCLE  = 4'b1000
	} rtc_state_type;

endpackage

// *** rtc_props.sv ***
`timescale 1ns/1ps
module rtc_props (
	input wire logic       clk_sys_i,
	input wire logic       rstn_i,
	input wire logic       sw_standby_i,
	input wire logic       area3_three_state_i,
	input wire logic       hreadyout_o,
	input wire logic       hresp_o,
	input wire logic       bus_request_o,
	input wire logic       refresh_active_o,
	input wire logic       refresh_strobe_n_o,
	input wire logic       refresh_strobe_oe_o,
	input wire logic       self_refresh_o,
	input wire logic       match_interrupt_o,
	input wire logic       dram_mode_o,
	input wire logic       psram_mode_o,
	input wire logic       two_cas_mode_o,
	input wire logic       col9_mode_o,
	input wire logic [1:0] area3_states_o,
	input wire logic       area3_wait_allow_o
);
	wire logic mem = dram_mode_o | psram_mode_o;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	// three states, then the sequencer leaves the cycle
	sequence s_cycle;
		refresh_active_o [*3] ##1 !refresh_active_o;
	endsequence
	a_bus_okay: assert property (hreadyout_o && !hresp_o)
		else $error("bus not ready or error response");
	a_one_mode: assert property (self_refresh_o
		|-> $past(dram_mode_o ^ psram_mode_o))
		else $error("self refresh without exactly one memory mode");
	a_three_states: assert property (area3_states_o == (mem ? 2'h3 : 2'h0))
		else $error("area 3 state count wrong");
	a_cycle_len: assert property ($rose(refresh_active_o) && !area3_three_state_i
		|-> s_cycle) else $error("refresh cycle length wrong");
	a_no_wait: assert property (area3_wait_allow_o
		== (mem && area3_three_state_i)) else $error("wait permission wrong");
	a_dram_only: assert property (two_cas_mode_o || col9_mode_o |-> dram_mode_o)
		else $error("strobe or column mode outside dynamic mode");
	a_pin_port: assert property (!refresh_strobe_oe_o |-> refresh_strobe_n_o)
		else $error("strobe low while pin is a port");
	a_strobe_low: assert property (refresh_active_o && refresh_strobe_oe_o
		|-> !refresh_strobe_n_o) else $error("strobe high in cycle");
	a_timer_quiet: assert property (!mem |-> !refresh_active_o && !bus_request_o)
		else $error("refresh activity in timer mode");
	a_irq_off: assert property (mem && $past(mem) |-> !match_interrupt_o)
		else $error("match interrupt in memory mode");
	a_self_std: assert property (self_refresh_o |-> $past(sw_standby_i))
		else $error("self refresh outside standby");
endmodule

// *** rtc_refresh_timer.sv ***
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - self-refresh in software standby when selected and one memory mode set
// - memory returns to normal access when software standby ends
// - enable pair picks timer, dynamic or pseudo-static; never both set
// - area 3 bus and refresh cycles last three states in memory mode
// - no area 3 wait states in memory mode when three-state bit clear
// - memory mode locks mode bits 4,3,2,0 and timer registers except flag clear
// - strobe select: 0 two-write-strobe, 1 two-column-strobe, dynamic mode only
// - column select: 0 eight-bit, 1 nine-bit column, dynamic mode only
// - refresh pin is port when pin enable 0, refresh signal when 1
// - reserved mode bit 1 and control bits 2..0 read one, ignore writes
// - refresh cycles only in a memory mode with cycle enable set
// - control bits 7,6 reset by any standby; bits 5..3 kept in software standby
// - match flag sets when counter equals constant
// - flag clears by read-as-one then write zero; writing one does nothing
// - interrupt enable gates match interrupt; forced zero in memory mode
// - tick select 000 stops, else clock divided by 2..4096
// - match gives refresh request in memory mode, interrupt in timer mode
// - counter increments per tick, clears on match with flag set
// - counter cleared by reset and any standby
// - constant set to ff by reset and hardware standby, kept in software standby
// - mode register set to 02 by reset and hardware standby
// - first request pends; next acquires bus and refreshes; requests during cycle ignored
// - refresh pin low through each refresh cycle when enabled
module rtc_refresh_timer
	import rtc_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        sw_standby_i,
	input  wire logic        hw_standby_i,
	input  wire logic        area3_three_state_i,
	input  wire logic        area3_wait_i,
	input  wire logic        bus_grant_i,
	output logic             bus_request_o,
	output logic             refresh_active_o,
	output logic             refresh_strobe_n_o,
	output logic             refresh_strobe_oe_o,
	output logic             self_refresh_o,
	output logic             match_interrupt_o,
	output logic             dram_mode_o,
	output logic             psram_mode_o,
	output logic             two_cas_mode_o,
	output logic             col9_mode_o,
	output logic [1:0]       area3_states_o,
	output logic             area3_wait_allow_o
);

	rtc_aphase_type ap_r;
	rtc_aphase_type ap_nxt;
	rtc_mode_type   mode_r;
	rtc_mode_type   mode_nxt;
	rtc_state_type  state_r;
	rtc_state_type  state_nxt;
	logic           flag_r;
	logic           flag_nxt;
	logic           ie_r;
	logic           ie_nxt;
	logic [2:0]     cks_r;
	logic [2:0]     cks_nxt;
	logic [7:0]     count_r;
	logic [7:0]     count_nxt;
	logic [7:0]     const_r;
	logic [7:0]     const_nxt;
	logic           armed_r;
	logic           armed_nxt;
	logic [11:0]    presc_r;
	logic [11:0]    presc_nxt;
	logic [1:0]     tstate_r;
	logic [1:0]     tstate_nxt;
	logic           self_r;
	logic           irq_r;

	// decode and selection
	wire        mem_mode = mode_r.psram | mode_r.dram;
	wire        one_mem  = mode_r.psram ^ mode_r.dram;
	wire        any_stby = sw_standby_i | hw_standby_i;
	wire        ap_take  = hsel_i & hready_i & htrans_i[1];
	wire        wr_act   = ap_r.valid & ap_r.write;
	wire        rd_act   = ap_r.valid & ~ap_r.write;
	wire [7:0]  wdat     = hwdata_i[7:0];
	wire        wr_mode  = wr_act & (ap_r.addr == RTC_OFS_MODE);
	wire        wr_csr   = wr_act & (ap_r.addr == RTC_OFS_CSR);
	wire        wr_count = wr_act & (ap_r.addr == RTC_OFS_COUNT);
	wire        wr_const = wr_act & (ap_r.addr == RTC_OFS_CONST);
	wire        rd_csr   = rd_act & (ap_r.addr == RTC_OFS_CSR);
	wire        unlocked = ~mem_mode;

	// timer and refresh
	wire [11:0] div_mask = RTC_DIV_MASK[cks_r];
	wire        tick     = (cks_r != 3'h0)
		& ((presc_r & div_mask) == div_mask);
	wire        match    = tick & (count_r == const_r);
	wire        ref_req  = match & mem_mode;
	wire        in_cycle = (state_r == RTC_ST_CYCLE);
	wire        wait_ins = area3_three_state_i & area3_wait_i;
	wire        flag_clr = wr_csr & armed_r & ~wdat[RTC_CSR_FLAG];
	wire        self_nxt = mode_r.self_refresh & one_mem
		& sw_standby_i;
	wire        irq_nxt  = flag_r & ie_r & ~mem_mode;

	wire [7:0] mode_rd = {mode_r.self_refresh, mode_r.psram, mode_r.dram,
		mode_r.two_cas, mode_r.col9, mode_r.pin_en, 1'b0,
		mode_r.rcyc_en} | RTC_MODE_RSVD;
	wire [7:0] csr_rd  = {flag_r, ie_r, cks_r, RTC_CSR_RSVD};

	// read data selection
	logic [7:0] rd_sel;

	always_comb begin
		case (ap_r.addr)
		RTC_OFS_MODE:  rd_sel = mode_rd;
		RTC_OFS_CSR:   rd_sel = csr_rd;
		RTC_OFS_COUNT: rd_sel = count_r;
		RTC_OFS_CONST: rd_sel = const_r;
		default:       rd_sel = 8'h00;
		endcase
	end

	// bus response
	assign hrdata_o    = rd_act ? {24'h000000, rd_sel} : 32'h00000000;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	// address phase capture
	always_comb begin
		ap_nxt.valid = ap_take;
		ap_nxt.write = hwrite_i;
		ap_nxt.addr  = {haddr_i[7:2], 2'b00};
	end

	// mode register
	always_comb begin
		mode_nxt = mode_r;
		if (wr_mode) begin
			mode_nxt.self_refresh = wdat[RTC_MODE_SELF];
			mode_nxt.psram        = wdat[RTC_MODE_PSRAM];
			mode_nxt.dram         = wdat[RTC_MODE_DRAM];
			if (unlocked) begin
				mode_nxt.two_cas = wdat[RTC_MODE_STRB];
				mode_nxt.col9    = wdat[RTC_MODE_COL9];
				mode_nxt.pin_en  = wdat[RTC_MODE_PIN];
				mode_nxt.rcyc_en = wdat[RTC_MODE_RCYC];
			end
		end
		if (hw_standby_i) begin
			mode_nxt = '0;
		end
	end

	// timer control and status
	always_comb begin
		ie_nxt    = ie_r;
		cks_nxt   = cks_r;
		armed_nxt = armed_r;
		if (wr_csr & unlocked) begin
			ie_nxt  = wdat[RTC_CSR_IE];
			cks_nxt = wdat[RTC_CSR_CKS +: 3];
		end
		if (mem_mode) begin
			ie_nxt = 1'b0;
		end
		if (rd_csr & flag_r) begin
			armed_nxt = 1'b1;
		end
		if (flag_clr | ~flag_r) begin
			armed_nxt = 1'b0;
		end
		flag_nxt = (flag_r & ~flag_clr) | match;
		if (any_stby) begin
			flag_nxt  = 1'b0;
			ie_nxt    = 1'b0;
			armed_nxt = 1'b0;
		end
		if (hw_standby_i) begin
			cks_nxt = RTC_CKS_RST;
		end
	end

	// counter and constant
	always_comb begin
		presc_nxt = presc_r + 12'h001;
		count_nxt = count_r;
		const_nxt = const_r;
		if (tick) begin
			count_nxt = match ? RTC_COUNT_RST : count_r + 8'h01;
		end
		if (wr_count & unlocked) begin
			count_nxt = wdat;
		end
		if (wr_const & unlocked) begin
			const_nxt = wdat;
		end
		if (any_stby) begin
			count_nxt = RTC_COUNT_RST;
			presc_nxt = 12'h000;
		end
		if (hw_standby_i) begin
			const_nxt = RTC_CONST_RST;
		end
	end

	// refresh request and cycle sequencing
	always_comb begin
		state_nxt  = state_r;
		tstate_nxt = tstate_r;
		case (state_r)
		RTC_ST_IDLE: begin
			if (ref_req) begin
				state_nxt = RTC_ST_PEND;
			end
		end
		RTC_ST_PEND: begin
			if (ref_req & mode_r.rcyc_en) begin
				state_nxt = RTC_ST_BUSREQ;
			end
		end
		RTC_ST_BUSREQ: begin
			if (bus_grant_i) begin
				state_nxt  = RTC_ST_CYCLE;
				tstate_nxt = 2'h1;
			end
		end
		RTC_ST_CYCLE: begin
			if (tstate_r == RTC_CYCLE_STATES) begin
				state_nxt  = RTC_ST_PEND;
				tstate_nxt = 2'h0;
			end else if (!(tstate_r == RTC_WAIT_STATE && wait_ins)) begin
				tstate_nxt = tstate_r + 2'h1;
			end
		end
		default: begin
			state_nxt = RTC_ST_IDLE;
		end
		endcase
		if (~mem_mode | any_stby) begin
			state_nxt  = RTC_ST_IDLE;
			tstate_nxt = 2'h0;
		end
	end

	// state flip-flops
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ap_r <= '0;
		end else begin
			ap_r <= ap_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_r <= '0;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ie_r <= 1'b0;
		end else begin
			ie_r <= ie_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cks_r <= RTC_CKS_RST;
		end else begin
			cks_r <= cks_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			armed_r <= 1'b0;
		end else begin
			armed_r <= armed_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			count_r <= RTC_COUNT_RST;
		end else begin
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			const_r <= RTC_CONST_RST;
		end else begin
			const_r <= const_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			presc_r <= 12'h000;
		end else begin
			presc_r <= presc_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r <= RTC_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tstate_r <= 2'h0;
		end else begin
			tstate_r <= tstate_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			self_r <= 1'b0;
		end else begin
			self_r <= self_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// registered standby and interrupt
	assign self_refresh_o      = self_r;
	assign match_interrupt_o   = irq_r;

	// refresh sequencing and pin
	assign bus_request_o       = (state_r == RTC_ST_BUSREQ);
	assign refresh_active_o    = in_cycle;
	assign refresh_strobe_oe_o = mode_r.pin_en;
	assign refresh_strobe_n_o  = ~(in_cycle & mode_r.pin_en);

	// mode outputs to the bus controller
	assign dram_mode_o         = mode_r.dram & ~mode_r.psram;
	assign psram_mode_o        = mode_r.psram & ~mode_r.dram;
	assign two_cas_mode_o      = mode_r.two_cas & dram_mode_o;
	assign col9_mode_o         = mode_r.col9 & dram_mode_o;
	assign area3_states_o      = mem_mode ? RTC_CYCLE_STATES : 2'h0;
	assign area3_wait_allow_o  = mem_mode & area3_three_state_i;

endmodule

// *** tb_refresh_timer_control.sv ***
`timescale 1ns/1ps
module tb_refresh_timer_control
	import rtc_pkg::*;
;
	logic        clk_sys_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [1:0]  htrans_i = 2'h0;
	logic [31:0] haddr_i = '0, hwdata_i = '0, q, msk = '1;
	logic        hwrite_i = 1'b0, sw_standby_i = 1'b0, hw_standby_i = 1'b0;
	logic        area3_three_state_i = 1'b0;
	logic        hit;
	wire logic   hsel_i = 1'b1;
	wire logic [2:0] hsize_i = 3'h2;
	wire logic   hreadyout_o, hresp_o, bus_request_o, refresh_active_o;
	wire logic   refresh_strobe_n_o, refresh_strobe_oe_o, self_refresh_o;
	wire logic   match_interrupt_o, dram_mode_o, psram_mode_o, two_cas_mode_o;
	wire logic   col9_mode_o, area3_wait_allow_o, area3_wait_i, bus_grant_i;
	wire logic [1:0]  area3_states_o;
	wire logic [31:0] hrdata_o;
	wire logic   hready_i = hreadyout_o;
	int          bad_count = 0, checked = 0, n, rcnt, per;
	logic [23:0] rows [7] = '{24'h0c5a5a, 24'h083333, 24'h001d1f, 24'h000002,
		24'h04c047, 24'h040007, 24'h10ab00};
	logic [7:0]  rstv [4] = '{8'h02, 8'h07, 8'h00, 8'hff};
	rtc_refresh_timer i_rtc_refresh_timer (.*);
	rtc_mem_model i_rtc_mem_model (.clk_sys_i, .rstn_i,
		.bus_request_i(bus_request_o), .refresh_active_i(refresh_active_o),
		.refresh_strobe_n_i(refresh_strobe_n_o), .bus_grant_o(bus_grant_i),
		.refresh_strobe_oe_i(refresh_strobe_oe_o), .area3_wait_o(area3_wait_i),
		.refresh_count_o(rcnt));
	always #12.5 clk_sys_i = ~clk_sys_i;
	task automatic chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk_sys_i);
		htrans_i <= 2'h2;
		haddr_i <= {24'h0, a};
		hwrite_i <= w;
		@(posedge clk_sys_i);
		while (!hreadyout_o) @(posedge clk_sys_i);
		htrans_i <= 2'h0;
		hwdata_i <= {24'h0, d};
		@(posedge clk_sys_i);
		while (!hreadyout_o) @(posedge clk_sys_i);
		q = hrdata_o;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		xfer(a, 1'b0, 8'h00);
		chk($sformatf("register %h", a), {24'h0, e} & msk, q & msk);
	endtask
	task automatic rst_chk;
		for (int i = 0; i < 4; i++) rc(8'(i * 4), rstv[i]);
	endtask
	task automatic conclude;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#(25 * 30000);
		bad_count++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		rst_chk();
		foreach (rows[i]) begin
			xfer(rows[i][23:16], 1'b1, rows[i][15:8]);
			rc(rows[i][23:16], rows[i][7:0]);
		end
		for (int c = 0; c < 4; c++) begin
			xfer(RTC_OFS_COUNT, 1'b1, 8'h00);
			xfer(RTC_OFS_CONST, 1'b1, 8'h03);
			xfer(RTC_OFS_CSR, 1'b1, {2'b01, 3'(c), 3'h0});
			n = 0;
			per = (1 << (2 * c)) / 2;
			while (!match_interrupt_o && n < 160) begin
				@(posedge clk_sys_i);
				n++;
			end
			hit = c ? match_interrupt_o === 1'b1 && n >= 3 * per
				&& n <= 4 * per + 4 : !match_interrupt_o;
			chk("irq period", 1, hit);
			xfer(RTC_OFS_CSR, 1'b1, 8'h40);
			rc(RTC_OFS_CSR, c ? 8'hc7 : 8'h47);
			xfer(RTC_OFS_CSR, 1'b1, 8'h40);
			rc(RTC_OFS_CSR, 8'h47);
			chk("irq clear", 0, match_interrupt_o);
		end
		xfer(RTC_OFS_CSR, 1'b1, 8'h08);
		xfer(RTC_OFS_MODE, 1'b1, 8'h1d);
		xfer(RTC_OFS_MODE, 1'b1, 8'h3d);
		rc(RTC_OFS_MODE, 8'h3f);
		xfer(RTC_OFS_MODE, 1'b1, 8'h20);
		rc(RTC_OFS_MODE, 8'h3f);
		xfer(RTC_OFS_CONST, 1'b1, 8'h11);
		rc(RTC_OFS_CONST, 8'h03);
		xfer(RTC_OFS_CSR, 1'b1, 8'h68);
		msk = 32'h7f;
		rc(RTC_OFS_CSR, 8'h0f);
		chk("strobe modes", 3, {two_cas_mode_o, col9_mode_o});
		for (int k = 1; k <= 2; k++) begin
			area3_three_state_i <= k == 2;
			n = 0;
			while (rcnt < 2 * k && n < 500) begin
				@(posedge clk_sys_i);
				n++;
			end
			chk("refresh count", 1, rcnt >= 2 * k);
		end
		xfer(RTC_OFS_MODE, 1'b1, 8'hbd);
		rc(RTC_OFS_MODE, 8'hbf);
		sw_standby_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		chk("self refresh", 1, self_refresh_o);
		msk = '1;
		rc(RTC_OFS_COUNT, 8'h00);
		rc(RTC_OFS_CONST, 8'h03);
		rc(RTC_OFS_CSR, 8'h0f);
		sw_standby_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		chk("self refresh", 0, self_refresh_o);
		hw_standby_i <= 1'b1;
		@(posedge clk_sys_i);
		hw_standby_i <= 1'b0;
		rst_chk();
		xfer(RTC_OFS_CONST, 1'b1, 8'h03);
		xfer(RTC_OFS_CSR, 1'b1, 8'h08);
		xfer(RTC_OFS_MODE, 1'b1, 8'h5c);
		per = rcnt;
		repeat (40) @(posedge clk_sys_i);
		chk("no refresh", per, rcnt);
		q = {28'h0, dram_mode_o, psram_mode_o, two_cas_mode_o, col9_mode_o};
		chk("pseudo-static modes", 32'h4, q);
		chk("area 3 states", 3, area3_states_o);
		chk("strobe pin enable", 1, refresh_strobe_oe_o);
		chk("irq in memory mode", 0, match_interrupt_o);
		conclude();
	end
endmodule
bind rtc_refresh_timer rtc_props i_rtc_props (.*);
